//--- hw/quhbs_top.sv
// Host bus front end of a four channel UART: style strap, channel and
// register decode, strobe handling, interrupt routing.
// Assumes synchronous pin inputs; register contents live outside.
// Style is fixed once per reset; the strap is not watched after that.
// Function
// R1 - Strap high selects the strobe style and low the single-select style.
// R2 - The strap has a pull-up so a floating strap means strobe style.
// R3 - In single-select style the write pin is a direction input and reset is active low.
// R4 - In single-select style the read strobe is ignored.
// R5 - In single-select style the four interrupts are ORed onto one open-source output.
// R6 - Three register index bits pick the register within the selected channel.
// R7 - In single-select style the shared select low enables the channels, picked by index.
// R8 - Channel index bits are honoured only while the shared select is low.
// R9 - In strobe style the channel index pins are the B and C selects.
// R10 - In strobe style the shared select pin is the channel A select.
// R11 - In strobe style only channels whose select is low may transfer.
// R12 - In strobe style a falling read strobe drives the chosen register onto the data bus.
// R13 - In strobe style a falling write strobe moves bus data into the chosen register.
// R14 - Channel index values 0 to 3 map to channels A to D.
`default_nettype none
module quhbs_top
    import quhbs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic style_strap_in,
    input wire logic style_strap_oe_in,
    input wire logic shared_select_n_in,
    input wire logic [quhbs_pkg::CHAN_IDX_W-1:0] channel_index_in,
    input wire logic channel_d_select_n_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic pin_reset_in,
    input wire logic [quhbs_pkg::REG_IDX_W-1:0] register_index_in,
    input wire logic [quhbs_pkg::DATA_W-1:0] data_in,
    output logic [quhbs_pkg::DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [quhbs_pkg::NUM_CHAN-1:0] chan_irq_in,
    input wire logic [quhbs_pkg::DATA_W-1:0] rd_data_in [quhbs_pkg::NUM_CHAN],
    output logic [quhbs_pkg::NUM_CHAN-1:0] rd_req_out,
    output logic [quhbs_pkg::NUM_CHAN-1:0] wr_req_out,
    output logic [quhbs_pkg::REG_IDX_W-1:0] reg_addr_out,
    output logic [quhbs_pkg::DATA_W-1:0] wr_data_out,
    output logic [quhbs_pkg::NUM_CHAN-1:0] irq_out,
    output logic [quhbs_pkg::NUM_CHAN-1:0] irq_oe_out,
    output logic shared_irq_out,
    output logic shared_irq_oe_out,
    output logic uart_reset_out,
    output logic style_out
);
    import quhbs_pkg::*;

    // Refuse package settings that the fixed pin map cannot serve
    if (NUM_CHAN != (1 << CHAN_IDX_W))
    begin : g_chan_count_check
        $error("channel count does not match the channel index width");
    end
    // Channel codes are two index bits wide
    if (CHAN_IDX_W != $bits(CHAN_A))
    begin : g_chan_code_check
        $error("channel index width does not match the channel codes");
    end
    // The last channel code must name the last channel
    if (int'(CHAN_D) != NUM_CHAN - 1)
    begin : g_chan_last_check
        $error("channel codes do not cover every channel");
    end
    // Both strap levels must decode to different styles
    if (STYLE_STROBE == STYLE_SINGLE)
    begin : g_style_check
        $error("strap levels for the two styles are equal");
    end
    // A register index needs at least one bit
    if (REG_IDX_W < 1)
    begin : g_reg_idx_check
        $error("register index width is zero");
    end

    // Level seen on a strap pin that has a pull-up behind it
    function automatic logic pulled_up(input logic level, input logic driven);
        return driven ? level : 1'b1;
    endfunction

    // First clock of an activity: live now, not live on the last clock
    function automatic logic access_edge(input logic live, input logic was);
        return live & !was;
    endfunction

    // Request word, one bit per selected channel: the selects, or nothing without a start
    function automatic logic [NUM_CHAN-1:0] req_vector(
        input logic start,
        input logic [NUM_CHAN-1:0] sel
    );
        return start ? sel : '0;
    endfunction

    // Byte of the selected channel; with several selects the highest wins,
    // so a host that selects two channels at once reads only one of them
    function automatic logic [DATA_W-1:0] pick_byte(
        input logic [NUM_CHAN-1:0] sel,
        input logic [DATA_W-1:0] chan_bytes [NUM_CHAN]
    );
        logic [DATA_W-1:0] v;
        v = '0;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            if (sel[i])
            begin
                v = chan_bytes[i];
            end
        end
        return v;
    endfunction

    // Reset seen by the channel cores: high-active pin in strobe style,
    // low-active pin in single-select style
    function automatic logic reset_level(input logic strobe, input logic pin);
        return strobe ? pin : !pin;
    endfunction

    // Strap modelled with a pull-up: undriven reads as strobe style
    wire strap_level = pulled_up(style_strap_in, style_strap_oe_in); // R2
    logic style_r;
    logic strap_taken_r;

    // Strap caught on the first clock after reset release, then held;
    // a strap that moves later is ignored, as the bus style cannot
    // change under a running host
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            style_r <= STYLE_STROBE;
        end
        else if (!strap_taken_r)
        begin
            style_r <= strap_level; // R1
        end
    end

    // Marks the strap as taken
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            strap_taken_r <= 1'b0;
        end
        else
        begin
            strap_taken_r <= 1'b1;
        end
    end
    wire strobe_mode = (style_r == STYLE_STROBE);

    wire [NUM_CHAN-1:0] chan_sel;
    quhbs_sel u_sel (
        .style_in(style_r),
        .shared_select_n_in(shared_select_n_in),
        .channel_b_select_n_in(channel_index_in[0]),
        .channel_c_select_n_in(channel_index_in[1]),
        .channel_d_select_n_in(channel_d_select_n_in),
        .channel_index_in(channel_index_in),
        .chan_sel_out(chan_sel)
    );

    // Activity per style; the read pin is unused in single style, where
    // the write pin gives the direction (high reads, low writes)
    wire strobe_rd = !read_strobe_n_in;
    wire strobe_wr = !write_strobe_n_in;
    wire single_rd = write_strobe_n_in; // R4
    wire single_wr = !write_strobe_n_in; // R3
    wire rd_active = strobe_mode ? strobe_rd : single_rd; // R3 R4
    wire wr_active = strobe_mode ? strobe_wr : single_wr; // R3
    // Nothing happens without a selected channel
    wire any_sel = |chan_sel;
    wire rd_live = rd_active & any_sel;
    wire wr_live = wr_active & any_sel;
    logic rd_prev_r;
    logic wr_prev_r;

    // Read activity of the last clock; reset to idle so that no false
    // start follows reset
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_prev_r <= 1'b0;
        end
        else
        begin
            rd_prev_r <= rd_live;
        end
    end

    // Write activity of the last clock
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_prev_r <= 1'b0;
        end
        else
        begin
            wr_prev_r <= wr_live;
        end
    end

    // Strobe edge (or select edge in single style) starts one access;
    // a held strobe does not repeat it
    wire rd_start = access_edge(rd_live, rd_prev_r); // R12
    wire wr_start = access_edge(wr_live, wr_prev_r); // R13
    wire addr_take = rd_start | wr_start;

    // Read request pulse, one clock, to the selected channel only
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_req_out <= '0;
        end
        else
        begin
            rd_req_out <= req_vector(rd_start, chan_sel); // R11
        end
    end

    // Write request pulse, one clock, to the selected channel only
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_req_out <= '0;
        end
        else
        begin
            wr_req_out <= req_vector(wr_start, chan_sel); // R11
        end
    end

    // Register index held from one access start to the next
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_addr_out <= '0;
        end
        else if (addr_take)
        begin
            reg_addr_out <= register_index_in; // R6
        end
    end

    // Write byte captured with the write start
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_data_out <= '0;
        end
        else if (wr_start)
        begin
            wr_data_out <= data_in; // R13
        end
    end

    // Read byte of the selected channel
    wire [DATA_W-1:0] rd_mux = pick_byte(chan_sel, rd_data_in);

    // Read byte registered, so the bus shows a settled value
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_out <= '0;
        end
        else
        begin
            data_out <= rd_mux; // R12
        end
    end

    // Bus drive follows read activity one clock later and drops one clock after it
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_oe_out <= 1'b0;
        end
        else
        begin
            data_oe_out <= rd_live; // R12
        end
    end

    // Interrupt routing: per channel in strobe style, wired-OR otherwise
    wire any_irq = |chan_irq_in;
    assign irq_out = chan_irq_in;
    assign irq_oe_out = strobe_mode ? {NUM_CHAN{1'b1}} : '0;
    // Open-source shared line: driven only while some channel asks
    assign shared_irq_out = any_irq; // R5
    assign shared_irq_oe_out = !strobe_mode & any_irq; // R5
    // Reset pin polarity follows the style
    assign uart_reset_out = reset_level(strobe_mode, pin_reset_in); // R3
    assign style_out = style_r;
endmodule
`default_nettype wire

//--- hw/quhbs_pkg.sv
// Package for the quad UART host bus select front end.
// Assumes a single 40 MHz core clock and synchronous pin inputs.
`default_nettype none
package quhbs_pkg;
    // Bus-style strap levels
    localparam logic STYLE_STROBE = 1'b1;
    localparam logic STYLE_SINGLE = 1'b0;
    // Widths
    localparam int REG_IDX_W = 3;
    localparam int CHAN_IDX_W = 2;
    localparam int NUM_CHAN = 4;
    localparam int DATA_W = 8;
    // Channel codes
    localparam logic [1:0] CHAN_A = 2'h0;
    localparam logic [1:0] CHAN_B = 2'h1;
    localparam logic [1:0] CHAN_C = 2'h2;
    localparam logic [1:0] CHAN_D = 2'h3;
    // Access kinds
    typedef enum {ACC_IDLE, ACC_BUSY} quhbs_acc_t;
endpackage
`default_nettype wire

//--- hw/quhbs_sel.sv
// Channel select decoder for the quad UART host front end.
// Assumes the strap has been latched already; purely combinational.
`default_nettype none
module quhbs_sel
    import quhbs_pkg::*;
(
    input wire logic style_in,
    input wire logic shared_select_n_in,
    input wire logic channel_b_select_n_in,
    input wire logic channel_c_select_n_in,
    input wire logic channel_d_select_n_in,
    input wire logic [quhbs_pkg::CHAN_IDX_W-1:0] channel_index_in,
    output logic [quhbs_pkg::NUM_CHAN-1:0] chan_sel_out
);
    // One-hot decode of a two bit channel code
    function automatic logic [NUM_CHAN-1:0] onehot(input logic [CHAN_IDX_W-1:0] idx);
        logic [NUM_CHAN-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    wire [NUM_CHAN-1:0] strobe_sel;
    wire [NUM_CHAN-1:0] single_sel;
    // Strobe style: each pin is its own channel select
    assign strobe_sel = {~channel_d_select_n_in, ~channel_c_select_n_in,
                         ~channel_b_select_n_in, ~shared_select_n_in}; // R9 R10 R11
    // Single style: index honoured only with the shared select low
    assign single_sel = shared_select_n_in ? '0 : onehot(channel_index_in); // R7 R8 R14
    assign chan_sel_out = (style_in == STYLE_STROBE) ? strobe_sel : single_sel; // R1
endmodule
`default_nettype wire

//--- tb/quhbs_asserts.sv
// Port checker for quhbs_top, bound at the foot of this file.
// Assumes one clock domain and the async active-low reset.
`default_nettype none
module quhbs_asserts
    import quhbs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic style_out,
    input wire logic shared_select_n_in,
    input wire logic [1:0] channel_index_in,
    input wire logic channel_d_select_n_in,
    input wire logic [2:0] register_index_in,
    input wire logic [3:0] chan_irq_in,
    input wire logic pin_reset_in,
    input wire logic [3:0] rd_req_out,
    input wire logic [3:0] wr_req_out,
    input wire logic [2:0] reg_addr_out,
    input wire logic data_oe_out,
    input wire logic [3:0] irq_oe_out,
    input wire logic shared_irq_oe_out,
    input wire logic uart_reset_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Request pulse, and no channel selected at the taking edge
    wire logic any_req = |{rd_req_out, wr_req_out};
    sequence req_s; any_req; endsequence
    sequence unsel_s; style_out ? $past(&{shared_select_n_in, channel_index_in,
        channel_d_select_n_in}) : $past(shared_select_n_in); endsequence
    rst_pol_a: assert property (uart_reset_out == (pin_reset_in ~^ style_out))
        else $error("reset polarity wrong");
    irq_route_a: assert property (irq_oe_out == {4{style_out}})
        else $error("channel irq enable wrong");
    shared_irq_a: assert property (shared_irq_oe_out == (!style_out && |chan_irq_in))
        else $error("shared irq enable wrong");
    no_select_a: assert property (unsel_s |-> !any_req)
        else $error("request without select");
    chan_map_a: assert property (!style_out && |rd_req_out |->
        rd_req_out == 4'h1 << $past(channel_index_in))
        else $error("channel index decode wrong");
    reg_addr_a: assert property (req_s |-> reg_addr_out == $past(register_index_in))
        else $error("register index not passed");
    read_oe_a: assert property (|rd_req_out |-> data_oe_out)
        else $error("read without bus drive");
    pulse_a: assert property (req_s |=> !any_req)
        else $error("request longer than one cycle");
endmodule
bind quhbs_top quhbs_asserts chk (.core_clk_in, .rst_n_in, .style_out, .shared_select_n_in,
    .channel_index_in, .channel_d_select_n_in, .register_index_in, .chan_irq_in,
    .pin_reset_in, .rd_req_out, .wr_req_out, .reg_addr_out, .data_oe_out, .irq_oe_out,
    .shared_irq_oe_out, .uart_reset_out);
`default_nettype wire

//--- tb/quhbs_chan_model.sv
// Stand-in for the four channel cores behind the front end.
// Assumes its bytes feed rd_data_in; distinct per channel so a wrong pick shows.
`default_nettype none
module quhbs_chan_model
    import quhbs_pkg::*;
(
    output logic [7:0] rd_data_out [4]
);
    timeunit 1ns;
    timeprecision 100ps;
    assign rd_data_out = '{8'h50, 8'h51, 8'h52, 8'h53};
endmodule
`default_nettype wire

//--- tb/quhbs_top_tb.sv
// Bench for quhbs_top: strap styles, selects, strobes, irq and reset routing.
// Assumes the channel model and the bound checker compile ahead of it.
`default_nettype none
module quhbs_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import quhbs_pkg::*;
    logic clk = 0, rst_n = 0, strap = 0, soe = 0, sa_n = 1, sd_n = 1, rd_n = 1, wr_n = 1;
    logic pin = 1, doe, sirq, sioe, urst, style;
    logic [1:0] cidx = 2'h3;
    logic [2:0] ridx = 3'h5, raddr;
    logic [3:0] irq = 4'h0, rreq, wreq, iout, ioe;
    logic [7:0] din = 8'hA7, dout, wdat;
    logic [7:0] rdat [4];
    int bad_count = 0;
    int check_count = 0;
    // Free-running 40 MHz core clock
    always #12.5 clk = ~clk;
    quhbs_chan_model cores (.rd_data_out(rdat));
    quhbs_top uut (.core_clk_in(clk), .rst_n_in(rst_n), .style_strap_in(strap),
        .style_strap_oe_in(soe), .shared_select_n_in(sa_n), .channel_index_in(cidx),
        .channel_d_select_n_in(sd_n), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
        .pin_reset_in(pin), .register_index_in(ridx), .data_in(din), .data_out(dout),
        .data_oe_out(doe), .chan_irq_in(irq), .rd_data_in(rdat), .rd_req_out(rreq),
        .wr_req_out(wreq), .reg_addr_out(raddr), .wr_data_out(wdat), .irq_out(iout),
        .irq_oe_out(ioe), .shared_irq_out(sirq), .shared_irq_oe_out(sioe),
        .uart_reset_out(urst), .style_out(style));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Five-cycle reset; strap floating when oe is low
    task automatic do_reset(input logic lvl, input logic oe);
        @(posedge clk);
        {strap, soe, rst_n} <= {lvl, oe, 1'b0};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // Hold select and strobes until a pulse or the bound; s_n is {d, index, a}
    task automatic access(input logic [3:0] s_n, input logic r, w, input logic [3:0] er, ew);
        int k;
        {sd_n, cidx, sa_n, rd_n, wr_n} <= {s_n, r, w};
        for (k = 0; k < 4 && (rreq | wreq) === 4'h0; k++)
            @(negedge clk);
        chk(8'(rreq), 8'(er));
        chk(8'(wreq), 8'(ew));
        if (k == 4 && (er | ew) != 4'h0)
            complete_run();
    endtask
    // Release everything and leave the gap cycle before the next access
    task automatic idle();
        @(posedge clk);
        {sd_n, cidx, sa_n, rd_n, wr_n} <= 6'h3F;
        repeat (2) @(posedge clk);
    endtask
    task automatic strobe_rw();
        chk(8'(style), 8'h1);
        access(4'b1101, 1'b0, 1'b1, 4'h2, 4'h0);
        chk(8'(raddr), 8'h5);
        chk(8'(doe), 8'h1);
        chk(dout, 8'h51);
        idle();
        chk(8'(doe), 8'h0);
        access(4'b1110, 1'b1, 1'b0, 4'h0, 4'h1);
        chk(wdat, 8'hA7);
        idle();
        access(4'b1011, 1'b0, 1'b1, 4'h4, 4'h0);
        chk(dout, 8'h52);
        idle();
        access(4'b0111, 1'b0, 1'b1, 4'h8, 4'h0);
        chk(dout, 8'h53);
        idle();
        access(4'b1111, 1'b0, 1'b1, 4'h0, 4'h0);
        idle();
    endtask
    task automatic irq_route();
        irq <= 4'h5;
        @(negedge clk);
        chk({ioe, iout}, 8'hF5);
        chk(8'({sirq, sioe, urst}), 8'h5);
        do_reset(1'b0, 1'b1);
        chk(8'({style, sirq, sioe, urst}), 8'h6);
        irq <= 4'h0;
        @(negedge clk);
        chk(8'({sirq, sioe}), 8'h0);
        @(posedge clk);
    endtask
    task automatic single_rw();
        for (int c = 0; c < 4; c++)
        begin
            access({1'b1, 2'(c), 1'b0}, 1'b1, 1'b1, 4'(1 << c), 4'h0);
            chk(dout, 8'h50 + 8'(c));
            idle();
        end
        access(4'b1010, 1'b0, 1'b0, 4'h0, 4'h2);
        idle();
        access(4'b1001, 1'b1, 1'b1, 4'h0, 4'h0);
        idle();
    endtask
    initial
    begin
        do_reset(1'b0, 1'b0);
        strobe_rw();
        irq_route();
        single_rw();
        complete_run();
    end
endmodule
`default_nettype wire
